/* src/txmcs_select.sv */
// Purpose: Transmit multichannel enable/mask decision over 128 channels
// Assumes: APB slave, single clock, synchronous active-low reset
// Notes:   Channel query returns a registered enable/unmask pair
// Function
// (RULE1) Partition mode zero: only word 0, 32 channels
// (RULE2) Partition mode one: all four words used
// (RULE3) Partition mode ignored when mode is zero
// (RULE4) Mode zero: low half A, high half B
// (RULE5) Mode one: word 0 maps channels 0-31
// (RULE6) Mode 1h: clear bit disables and masks
// (RULE7) Mode 2h: all enabled, clear bit masks
// (RULE8) Mode 3h: clear tx bit masks channel
// (RULE9) Mode 3h: set tx bit unmasks channel
// (RULE10) Mode 3h: enables come from receive words
// (RULE11) 32-channel, 1h/2h: even block from tx A
// (RULE12) 32-channel, 1h/2h: odd block from tx B
// (RULE13) 32-channel, 3h: blocks from receive selects
// (RULE14) Bit k to channel n+k, 16+k to m+k
// (RULE15) Words 1-3 govern channels 32 to 127
`timescale 1ns/100ps
module txmcs_select (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Per-channel decision vectors
    output logic [127:0]     tx_chan_enabled,
    output logic [127:0]     tx_chan_unmasked
);

    logic [31:0]  tx_en_reg [4];
    logic [31:0]  rx_en_reg [4];
    logic [31:0]  ctrl_reg;
    logic [6:0]   chan_sel_reg;
    logic [127:0] tx_bits;
    logic [127:0] rx_bits;
    logic [127:0] tx_eff;
    logic [127:0] rx_eff;
    logic [127:0] en_next;
    logic [127:0] um_next;
    logic         access;
    logic         wr;
    logic         rd_hit;
    logic [31:0]  rd_next;

    txmcs_pkg::txmcs_mode_e mode;
    logic         tx_pme;
    logic         rx_pme;
    logic         part_wide;
    logic [1:0]   blk_a;
    logic [1:0]   blk_b;

    assign access = psel && penable;
    assign wr     = access && pwrite;

    // Register writes
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                tx_en_reg[i] <= txmcs_pkg::EN_RESET;
                rx_en_reg[i] <= txmcs_pkg::EN_RESET;
            end
            ctrl_reg     <= txmcs_pkg::CTRL_RESET;
            chan_sel_reg <= 7'h00;
        end else if (wr) begin
            unique case (paddr)
                txmcs_pkg::ADDR_TX_EN0:  tx_en_reg[0] <= pwdata;
                txmcs_pkg::ADDR_TX_EN1:  tx_en_reg[1] <= pwdata;
                txmcs_pkg::ADDR_TX_EN2:  tx_en_reg[2] <= pwdata;
                txmcs_pkg::ADDR_TX_EN3:  tx_en_reg[3] <= pwdata;
                txmcs_pkg::ADDR_RX_EN0:  rx_en_reg[0] <= pwdata;
                txmcs_pkg::ADDR_RX_EN1:  rx_en_reg[1] <= pwdata;
                txmcs_pkg::ADDR_RX_EN2:  rx_en_reg[2] <= pwdata;
                txmcs_pkg::ADDR_RX_EN3:  rx_en_reg[3] <= pwdata;
                txmcs_pkg::ADDR_MC_CTRL: ctrl_reg <= {20'h00000,
                                                      pwdata[11:0]};
                txmcs_pkg::ADDR_CHAN_SEL: chan_sel_reg <= pwdata[6:0];
                default: ;
            endcase
        end
    end

    // Control fields
    assign mode   = txmcs_pkg::txmcs_mode_e'(
                    ctrl_reg[txmcs_pkg::CTRL_MODE_LSB +: 2]);
    assign tx_pme = ctrl_reg[txmcs_pkg::CTRL_XPME_BIT];
    assign rx_pme = ctrl_reg[txmcs_pkg::CTRL_RPME_BIT];
    // Partition bit only counts when a selection mode is active
    assign part_wide = (mode != txmcs_pkg::TXMCS_ALL_ON) && tx_pme; // RULE3

    // Block selects come from the receive side in symmetric mode
    always_comb begin
        if (mode == txmcs_pkg::TXMCS_SYMMETRIC) begin
            blk_a = ctrl_reg[txmcs_pkg::CTRL_RABLK_LSB +: 2]; // RULE13
            blk_b = ctrl_reg[txmcs_pkg::CTRL_RBBLK_LSB +: 2]; // RULE13
        end else begin
            blk_a = ctrl_reg[txmcs_pkg::CTRL_XABLK_LSB +: 2]; // RULE11
            blk_b = ctrl_reg[txmcs_pkg::CTRL_XBBLK_LSB +: 2]; // RULE12
        end
    end

    // Wide layout: words in ascending channel order
    assign tx_bits = {tx_en_reg[3], tx_en_reg[2],
                      tx_en_reg[1], tx_en_reg[0]};  // RULE2 RULE5 RULE15
    assign rx_bits = {rx_en_reg[3], rx_en_reg[2],
                      rx_en_reg[1], rx_en_reg[0]};

    // Narrow layout: word 0 halves land on selected even and odd blocks
    genvar g;
    generate
        for (g = 0; g < txmcs_pkg::NUM_CHAN; g++) begin : g_chan
            localparam int BLK = g / txmcs_pkg::BLK_SIZE;
            localparam int K   = g % txmcs_pkg::BLK_SIZE;
            localparam logic [1:0] PAIR = 2'(BLK / 2);
            logic tx_narrow;
            logic rx_narrow;
            if (BLK % 2 == 0) begin : g_even
                assign tx_narrow = (blk_a == PAIR) &&
                                   tx_en_reg[0][K];          // RULE4 RULE14
                assign rx_narrow = (blk_a == PAIR) && rx_en_reg[0][K];
            end else begin : g_odd
                assign tx_narrow = (blk_b == PAIR) &&
                                   tx_en_reg[0][16 + K];     // RULE4 RULE14
                assign rx_narrow = (blk_b == PAIR) && rx_en_reg[0][16 + K];
            end
            assign tx_eff[g] = part_wide ? tx_bits[g] : tx_narrow; // RULE1
            assign rx_eff[g] = rx_pme ? rx_bits[g] : rx_narrow;
        end
    endgenerate

    // Mode decision per channel
    always_comb begin
        unique case (mode)
            txmcs_pkg::TXMCS_ALL_ON: begin
                en_next = '1;
                um_next = '1;
            end
            txmcs_pkg::TXMCS_SELECT: begin
                en_next = tx_eff;                            // RULE6
                um_next = tx_eff;                            // RULE6
            end
            txmcs_pkg::TXMCS_MASKSEL: begin
                en_next = '1;                                // RULE7
                um_next = tx_eff;                            // RULE7
            end
            txmcs_pkg::TXMCS_SYMMETRIC: begin
                en_next = rx_eff;                            // RULE10
                // Clear tx bit blocks output even if rx enables
                um_next = tx_eff;                            // RULE8 RULE9
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tx_chan_enabled  <= '0;
            tx_chan_unmasked <= '0;
        end else begin
            tx_chan_enabled  <= en_next;
            tx_chan_unmasked <= um_next;
        end
    end

    // Read mux
    always_comb begin
        rd_hit  = 1'b1;
        rd_next = 32'h0000_0000;
        unique case (paddr)
            txmcs_pkg::ADDR_TX_EN0:    rd_next = tx_en_reg[0];
            txmcs_pkg::ADDR_TX_EN1:    rd_next = tx_en_reg[1];
            txmcs_pkg::ADDR_TX_EN2:    rd_next = tx_en_reg[2];
            txmcs_pkg::ADDR_TX_EN3:    rd_next = tx_en_reg[3];
            txmcs_pkg::ADDR_RX_EN0:    rd_next = rx_en_reg[0];
            txmcs_pkg::ADDR_RX_EN1:    rd_next = rx_en_reg[1];
            txmcs_pkg::ADDR_RX_EN2:    rd_next = rx_en_reg[2];
            txmcs_pkg::ADDR_RX_EN3:    rd_next = rx_en_reg[3];
            txmcs_pkg::ADDR_MC_CTRL:   rd_next = ctrl_reg;
            txmcs_pkg::ADDR_CHAN_SEL:  rd_next = {25'h0000000, chan_sel_reg};
            // Reflects registered decision, one cycle behind config
            txmcs_pkg::ADDR_CHAN_STAT: rd_next = {30'h00000000,
                                       tx_chan_unmasked[chan_sel_reg],
                                       tx_chan_enabled[chan_sel_reg]};
            default: rd_hit = 1'b0;
        endcase
    end

    // Zero wait state: ready in the setup cycle's following access cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !rd_hit;
            prdata  <= (psel && !penable && !pwrite && rd_hit) ?
                       rd_next : 32'h0000_0000;
        end
    end

endmodule // txmcs_select

/* inc/txmcs_pkg.sv */
// Purpose: Constants and types for transmit multichannel selection
// Assumes: 32-bit APB, word aligned registers
// Notes:   Offsets of all registers are local choices
package txmcs_pkg;

    localparam logic [7:0]  ADDR_TX_EN0    = 8'h00;
    localparam logic [7:0]  ADDR_TX_EN1    = 8'h04;
    localparam logic [7:0]  ADDR_TX_EN2    = 8'h08;
    localparam logic [7:0]  ADDR_TX_EN3    = 8'h0c;
    localparam logic [7:0]  ADDR_RX_EN0    = 8'h10;
    localparam logic [7:0]  ADDR_RX_EN1    = 8'h14;
    localparam logic [7:0]  ADDR_RX_EN2    = 8'h18;
    localparam logic [7:0]  ADDR_RX_EN3    = 8'h1c;
    localparam logic [7:0]  ADDR_MC_CTRL   = 8'h20;
    localparam logic [7:0]  ADDR_CHAN_SEL  = 8'h24;
    localparam logic [7:0]  ADDR_CHAN_STAT = 8'h28;

    localparam logic [31:0] EN_RESET       = 32'h0000_0000;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

    // Control register field positions
    localparam int          CTRL_MODE_LSB  = 0;  // 2 bits
    localparam int          CTRL_XPME_BIT  = 2;
    localparam int          CTRL_RPME_BIT  = 3;
    localparam int          CTRL_XABLK_LSB = 4;  // 2 bits each
    localparam int          CTRL_XBBLK_LSB = 6;
    localparam int          CTRL_RABLK_LSB = 8;
    localparam int          CTRL_RBBLK_LSB = 10;

    localparam int          NUM_CHAN       = 128;
    localparam int          BLK_SIZE       = 16;

    typedef enum logic [1:0] {
        TXMCS_ALL_ON   = 2'b00,
        TXMCS_SELECT   = 2'b01,
        TXMCS_MASKSEL  = 2'b10,
        TXMCS_SYMMETRIC = 2'b11
    } txmcs_mode_e;

    typedef struct packed {
        logic enabled;
        logic unmasked;
    } txmcs_chan_s;

endpackage

/* verification/txmcs_select_assertions.sv */
// Purpose: Port-level checks for transmit multichannel selection
// Assumes: Control writes are visible on the APB port
// Notes:   Mode is shadowed here; outputs lag config by one edge
`timescale 1ns/100ps
module txmcs_select_chk (
    // Clock and reset
    input wire logic         core_clk,
    input wire logic         rst_n,
    // APB
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [7:0]   paddr,
    input wire logic [31:0]  pwdata,
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    input wire logic         pslverr,
    // Decisions
    input wire logic [127:0] tx_chan_enabled,
    input wire logic [127:0] tx_chan_unmasked
);
    logic [1:0] mode_reg;
    logic       hit;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    assign hit = paddr <= txmcs_pkg::ADDR_CHAN_STAT && paddr[1:0] == 2'h0;
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            mode_reg <= 2'h0;
        else if (psel && penable && pready && pwrite && paddr == 8'h20)
            mode_reg <= pwdata[1:0];
    end
    chk_ready_next: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    chk_err_unmapped: assert property (pready && !hit |-> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (pready && hit |-> !pslverr)
        else $error("mapped access refused");
    chk_idle_quiet: assert property (!pready |-> prdata == 0 && !pslverr)
        else $error("read bus not quiet");
    chk_mode_off_all: assert property (mode_reg == 2'h0 && $past(mode_reg) == 2'h0
        && $past(rst_n) |-> &tx_chan_enabled && &tx_chan_unmasked)
        else $error("mode zero not all on");
    chk_mask_mode_on: assert property (mode_reg == 2'h2 && $past(mode_reg) == 2'h2
        |-> &tx_chan_enabled)
        else $error("mask mode disabled a channel");
    chk_sel_mode_pair: assert property (mode_reg == 2'h1
        && $past(mode_reg) == 2'h1 |-> tx_chan_enabled == tx_chan_unmasked)
        else $error("select mode enable and unmask differ");
    cover property (mode_reg == 2'h3 && $past(mode_reg) == 2'h3);
    cover property (pready && pslverr);
    cover property (pready ##1 psel && !penable);
endmodule // txmcs_select_chk

/* verification/tb.sv */
// Purpose: Directed register test of transmit multichannel selection
// Assumes: One-cycle pready; outputs follow config one edge after a write
// Notes:   Expected vectors are rebuilt here from the channel mapping
`timescale 1ns/100ps
module tb;
    logic         core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic         err;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic [127:0] en_o, um_o, x_en, x_um;
    logic [31:0]  tx[4] = '{32'ha5c3_0f81, 32'h0ff0_1e2d, 32'h8001_7ffe, 32'h1357_9bdf};
    logic [31:0]  rx[4] = '{32'h5a3c_f07e, 32'hf00f_e1d2, 32'h7ffe_8001, 32'h2468_ace0};
    logic [11:0]  cfg[10] = '{12'h000, 12'h004, 12'h031, 12'h091, 12'h0c5,
                              12'h012, 12'h006, 12'he33, 12'h50f, 12'h627};
    int           err_count, n_compared;

    txmcs_select dut_u (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_chan_enabled(en_o), .tx_chan_unmasked(um_o));

    always #10 core_clk = ~core_clk;

    task automatic chk(input string nm, input logic [127:0] e, g);
        n_compared++;
        if (g !== e) begin
            $display("MISMATCH %s exp %h got %h", nm, e, g);
            err_count++;
        end
    endtask

    // Leaves the bus held so a following call starts its setup at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) err_count++;
        rd = prdata;
        err = pslverr;
    endtask

    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    function automatic logic [127:0] mapw(logic [31:0] w[4], logic wide,
                                          logic [1:0] a, logic [1:0] b);
        logic [127:0] v;
        v = '0;
        if (wide)
            v = {w[3], w[2], w[1], w[0]};
        else begin
            v[32 * a +: 16] = w[0][15:0];
            v[32 * b + 16 +: 16] = w[0][31:16];
        end
        return v;
    endfunction

    task automatic expect_cfg(input logic [11:0] c,
                              output logic [127:0] e_en, e_um);
        e_um = mapw(tx, c[2], c[5:4], c[7:6]);
        e_en = c[1:0] == 2'h1 ? e_um : '1;
        if (c[1:0] == 2'h3) begin
            e_en = mapw(rx, c[3], c[9:8], c[11:10]);
            e_um = mapw(tx, c[2], c[9:8], c[11:10]);
        end
        if (c[1:0] == 2'h0) e_um = '1;
        chk("enabled", e_en, en_o);
        chk("unmasked", e_um, um_o);
    endtask

    task final_report();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        core_clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; err_count = 0; n_compared = 0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < 4; i++) begin
            apb(0, 8'(4 * i), 32'h0);
            chk("tx_en reset", 32'h0, rd);
        end
        apb(1, 8'h30, 32'hffff_ffff);
        apb(0, 8'h30, 32'h0);
        chk("unmapped err", 1, err);
        chk("unmapped data", 0, rd);
        $display("test reset_map done");
        for (int i = 0; i < 4; i++) begin
            apb(1, 8'(4 * i), tx[i]);
            apb(1, 8'(8'h10 + 4 * i), rx[i]);
        end
        for (int i = 0; i < 4; i++) begin
            apb(0, 8'(4 * i), 32'h0);
            chk("tx_en readback", tx[i], rd);
            apb(0, 8'(8'h10 + 4 * i), 32'h0);
            chk("rx_en readback", rx[i], rd);
        end
        $display("test words done");
        foreach (cfg[k]) begin
            apb(1, txmcs_pkg::ADDR_MC_CTRL, {20'hfffff, cfg[k]});
            idle();
            @(posedge core_clk);
            expect_cfg(cfg[k], x_en, x_um);
            apb(0, txmcs_pkg::ADDR_MC_CTRL, 32'h0);
            chk("ctrl readback", {20'h0, cfg[k]}, rd);
            apb(1, txmcs_pkg::ADDR_CHAN_SEL, 32'(k * 13));
            apb(0, txmcs_pkg::ADDR_CHAN_SEL, 32'h0);
            chk("chan sel readback", 32'(k * 13), rd);
            apb(0, txmcs_pkg::ADDR_CHAN_STAT, 32'h0);
            chk("chan status", {126'h0, x_um[k * 13], x_en[k * 13]}, rd);
        end
        idle();
        $display("test modes done");
        final_report();
    end

    initial begin
        repeat (3000) @(posedge core_clk);
        err_count++;
        final_report();
    end
endmodule // tb

bind txmcs_select txmcs_select_chk chk_u (.core_clk(core_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_chan_enabled(tx_chan_enabled), .tx_chan_unmasked(tx_chan_unmasked));
